// *** hdl/gpio_ports.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_ports
  import gpio_port_pkg::*;
#(
  parameter bit PORT_C_WIDE = 1'b1
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [ADDR_W-1:0]              addr,
  input  wire logic [PORT_BITS-1:0]           wrData,
  input  wire logic                           wrEn,
  input  wire logic                           rdEn,
  output logic      [PORT_BITS-1:0]           rdData_q,
  input  wire logic [NUM_PORTS*PORT_BITS-1:0] pinIn,
  output logic      [NUM_PORTS*PORT_BITS-1:0] pinOut_q,
  output logic      [NUM_PORTS*PORT_BITS-1:0] pinOeN_q,
  output logic      [NUM_PORTS*PORT_BITS-1:0] pullOn_q,
  input  wire logic                           halted,
  output logic                                wakeReq_q
);

  localparam int NPIN = NUM_PORTS * PORT_BITS;

  function automatic logic [PORT_BITS-1:0] portMask(input int p);
    case (p)
      PORT_A:  portMask = MASK_A;
      PORT_C:  portMask = PORT_C_WIDE ? MASK_FULL : MASK_NIBBLE;
      PORT_F:  portMask = MASK_NIBBLE;
      default: portMask = MASK_FULL;
    endcase
  endfunction : portMask

  function automatic logic hit(input logic [ADDR_W-1:0] a, input int p,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == PORT_BASE[p] + ofs);
  endfunction : hit

  // Pin synchroniser; stage one is read only by stage two
  logic [NPIN-1:0] pinMeta_q;
  logic [NPIN-1:0] pinSync_q;
  logic [NPIN-1:0] pinPrev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      // Idle level of a pulled pin, matches the edge detector below
      pinMeta_q <= '1;
      pinSync_q <= '1;
    end else begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // Starts high so that reset release cannot fake a falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      pinPrev_q <= '1;
    end else begin
      pinPrev_q <= pinSync_q;
    end
  end

  port_reg_if portBus [NUM_PORTS] ();

  logic [PORT_BITS-1:0] dataV [NUM_PORTS];
  logic [PORT_BITS-1:0] dirV  [NUM_PORTS];
  logic [PORT_BITS-1:0] pullV [NUM_PORTS];
  logic [PORT_BITS-1:0] wakeV [NUM_PORTS];
  logic [PORT_BITS-1:0] readV [NUM_PORTS];
  logic [NUM_PORTS-1:0] selData;
  logic [NUM_PORTS-1:0] selDir;
  logic [NUM_PORTS-1:0] selPull;
  logic [NUM_PORTS-1:0] selWake;

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      localparam logic [PORT_BITS-1:0] M = portMask(p);

      assign selData[p] = hit(addr, p, OFS_DATA);
      assign selDir[p]  = hit(addr, p, OFS_DIR);
      assign selPull[p] = hit(addr, p, OFS_PULL);
      assign selWake[p] = (p == PORT_A) && hit(addr, p, OFS_WAKE);

      assign portBus[p].wrData   = wrData;
      assign portBus[p].wrDataEn = wrEn && selData[p];
      assign portBus[p].wrDirEn  = wrEn && selDir[p];
      assign portBus[p].wrPullEn = wrEn && selPull[p];
      assign portBus[p].wrWakeEn = wrEn && selWake[p];

      port_regs #(
        .MASK     (M),
        .HAS_WAKE (p == PORT_A)
      ) u_regs (
        .clk (clk),
        .rst (rst),
        .bus (portBus[p])
      );

      assign dataV[p] = portBus[p].dataQ;
      assign dirV[p]  = portBus[p].dirQ;
      assign pullV[p] = portBus[p].pullQ;
      assign wakeV[p] = portBus[p].wakeQ;

      // Inputs read the pin, outputs read the latch
      assign readV[p] = ((pinSync_q[p*PORT_BITS +: PORT_BITS] & dirV[p])
                        | (dataV[p] & ~dirV[p])) & M;

      // Unimplemented slots stay released with no pull
      always_ff @(posedge clk) begin
        if (rst) begin
          pinOut_q[p*PORT_BITS +: PORT_BITS] <= DATA_RST & M;
          pinOeN_q[p*PORT_BITS +: PORT_BITS] <= '1;
          pullOn_q[p*PORT_BITS +: PORT_BITS] <= PULL_RST;
        end else begin
          pinOut_q[p*PORT_BITS +: PORT_BITS] <= dataV[p];
          pinOeN_q[p*PORT_BITS +: PORT_BITS] <= dirV[p] | ~M;
          pullOn_q[p*PORT_BITS +: PORT_BITS] <= pullV[p] & dirV[p];
        end
      end
    end
  endgenerate

  // Register read, answered one edge after the read strobe
  logic [PORT_BITS-1:0] rdMux;

  always_comb begin
    rdMux = READ_RST;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (selData[i]) begin
        rdMux = readV[i];
      end else if (selDir[i]) begin
        rdMux = dirV[i];
      end else if (selPull[i]) begin
        rdMux = pullV[i];
      end else if (selWake[i]) begin
        rdMux = wakeV[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= READ_RST;
    end else if (rdEn) begin
      rdData_q <= rdMux;
    end
  end

  // Wake: falling edge on an enabled Port A pin while halted
  logic [PORT_BITS-1:0] fallA;

  assign fallA = pinPrev_q[PORT_BITS-1:0] & ~pinSync_q[PORT_BITS-1:0]
                 & wakeV[PORT_A] & MASK_A;

  // Held until the core leaves halt; an edge while not halted is ignored and the clear wins
  always_ff @(posedge clk) begin
    if (rst) begin
      wakeReq_q <= 1'b0;
    end else if (halted && (|fallA)) begin
      wakeReq_q <= 1'b1;
    end else if (!halted) begin
      wakeReq_q <= 1'b0;
    end
  end

endmodule : gpio_ports
`default_nettype wire

// *** common/gpio_port_pkg.sv ***
package gpio_port_pkg;

  localparam int NUM_PORTS = 6;
  localparam int PORT_BITS = 8;
  localparam int ADDR_W    = 8;

  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_E = 4;
  localparam int PORT_F = 5;

  // Data memory locations, one group of four per port
  localparam logic [ADDR_W-1:0] PORT_BASE [NUM_PORTS] = '{
    8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24
  };
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR  = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_PULL = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_WAKE = 8'h03;

  // Implemented bits per port
  localparam logic [PORT_BITS-1:0] MASK_A      = 8'h1F;
  localparam logic [PORT_BITS-1:0] MASK_FULL   = 8'hFF;
  localparam logic [PORT_BITS-1:0] MASK_NIBBLE = 8'h0F;

  localparam logic [PORT_BITS-1:0] DATA_RST = 8'hFF;
  localparam logic [PORT_BITS-1:0] DIR_RST  = 8'hFF;
  localparam logic [PORT_BITS-1:0] PULL_RST = 8'h00;
  localparam logic [PORT_BITS-1:0] WAKE_RST = 8'h00;
  localparam logic [PORT_BITS-1:0] READ_RST = 8'h00;

endpackage : gpio_port_pkg

// *** common/port_reg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface port_reg_if;
  logic [7:0] wrData;
  logic       wrDataEn;
  logic       wrDirEn;
  logic       wrPullEn;
  logic       wrWakeEn;
  logic [7:0] dataQ;
  logic [7:0] dirQ;
  logic [7:0] pullQ;
  logic [7:0] wakeQ;

  modport ctrl (
    output wrData, wrDataEn, wrDirEn, wrPullEn, wrWakeEn,
    input  dataQ, dirQ, pullQ, wakeQ
  );
  modport regs (
    input  wrData, wrDataEn, wrDirEn, wrPullEn, wrWakeEn,
    output dataQ, dirQ, pullQ, wakeQ
  );
endinterface : port_reg_if
`default_nettype wire

// *** hdl/port_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module port_regs
  import gpio_port_pkg::*;
#(
  parameter logic [PORT_BITS-1:0] MASK     = 8'hFF,
  parameter bit                   HAS_WAKE = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  port_reg_if.regs  bus
);

  // Unimplemented bits are never stored, so they read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.dataQ <= DATA_RST & MASK;
    end else if (bus.wrDataEn) begin
      bus.dataQ <= bus.wrData & MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.dirQ <= DIR_RST & MASK;
    end else if (bus.wrDirEn) begin
      bus.dirQ <= bus.wrData & MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus.pullQ <= PULL_RST;
    end else if (bus.wrPullEn) begin
      bus.pullQ <= bus.wrData & MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !HAS_WAKE) begin
      bus.wakeQ <= WAKE_RST;
    end else if (bus.wrWakeEn) begin
      bus.wakeQ <= bus.wrData & MASK;
    end
  end

endmodule : port_regs
`default_nettype wire

// *** tb/pin_env.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_env (
  input  wire logic        clk,
  input  wire logic [47:0] pinOut,
  input  wire logic [47:0] oeN,
  input  wire logic [47:0] pull,
  input  wire logic [47:0] extOn,
  input  wire logic [47:0] extVal,
  output logic      [47:0] pinIn
);
  // Undriven, unpulled pins toggle so a stale value never passes
  logic tgl = 1'b0;
  always @(posedge clk) tgl <= ~tgl;
  assign pinIn = (~oeN & pinOut) | (oeN & extOn & extVal)
    | (oeN & ~extOn & (pull | {48{tgl}}));
endmodule : pin_env
`default_nettype wire

// *** tb/gpio_ports_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_checker
  import gpio_port_pkg::*;
#(parameter bit PORT_C_WIDE = 1'b1) (
  input wire logic                           clk,
  input wire logic                           rst,
  input wire logic [ADDR_W-1:0]              addr,
  input wire logic [PORT_BITS-1:0]           wrData,
  input wire logic                           wrEn,
  input wire logic                           rdEn,
  input wire logic [PORT_BITS-1:0]           rdData_q,
  input wire logic [NUM_PORTS*PORT_BITS-1:0] pinIn,
  input wire logic [NUM_PORTS*PORT_BITS-1:0] pinOut_q,
  input wire logic [NUM_PORTS*PORT_BITS-1:0] pinOeN_q,
  input wire logic [NUM_PORTS*PORT_BITS-1:0] pullOn_q,
  input wire logic                           halted,
  input wire logic                           wakeReq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] pa1, pa2, pa3, pa4;
  always_ff @(posedge clk) begin
    {pa4, pa3, pa2, pa1} <= {pa3, pa2, pa1, pinIn[4:0]};
  end
  sequence wrDirB; wrEn && addr == 8'h15; endsequence
  sequence wrDataB; wrEn && addr == 8'h14; endsequence
  dir_to_pins_a: assert property (wrDirB ##2 1'b1 |-> pinOeN_q[15:8] == $past(wrData, 2))
    else $error("port B enable does not follow direction");
  data_to_pins_a: assert property (wrDataB ##2 1'b1 |-> pinOut_q[15:8] == $past(wrData, 2))
    else $error("port B drive does not follow latch");
  data_hold_a: assert property ($changed(pinOut_q[15:8]) |-> $past(wrEn && addr == 8'h14, 2))
    else $error("port B drive changed without write");
  reset_vals_a: assert property (@(posedge clk) disable iff (1'b0) rst |=>
    pinOeN_q == '1 && pullOn_q == '0 && pinOut_q[4:0] == 5'h1F && !wakeReq_q)
    else $error("reset values wrong");
  pull_input_a: assert property ((pullOn_q & ~pinOeN_q) == '0)
    else $error("pull on a driving pin");
  upper_zero_a: assert property (rdEn && addr[7:2] == 6'h04 |=> rdData_q[7:5] == 3'h0)
    else $error("port A upper bits not zero");
  unmapped_a: assert property (rdEn && addr == 8'h17 |=> rdData_q == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!rdEn |=> $stable(rdData_q))
    else $error("read data moved without read");
  wake_cause_a: assert property ($rose(wakeReq_q) |-> $past(halted)
    && |((pa4 & ~pa3) | (pa3 & ~pa2) | (pa2 & ~pa1)))
    else $error("wake without halted fall");
  wake_clear_a: assert property (!halted ##1 !halted |-> !wakeReq_q)
    else $error("wake held while running");
endmodule : gpio_ports_checker
bind gpio_ports gpio_ports_checker #(.PORT_C_WIDE(PORT_C_WIDE)) chk (.clk(clk), .rst(rst),
  .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData_q(rdData_q),
  .pinIn(pinIn), .pinOut_q(pinOut_q), .pinOeN_q(pinOeN_q), .pullOn_q(pullOn_q),
  .halted(halted), .wakeReq_q(wakeReq_q));
`default_nettype wire

// *** tb/gpio_ports_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_tb import gpio_port_pkg::*;;
  logic clk = 0, rst = 1, wrEn = 0, rdEn = 0, halted = 0, rdSeen = 0, wakeReq_q;
  logic [7:0] addr = 0, wrData = 0, rdData_q, pv[6], dv[6], dd[6], expQ[$];
  logic [47:0] pinIn, pinOut_q, pinOeN_q, pullOn_q, extVal = '1, extOn = '1;
  string nameQ[$];
  int n_mismatch = 0, checks = 0, seed = 32'hC8B81C62, i;
  always #25 clk = ~clk;
  gpio_ports uut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData_q(rdData_q), .pinIn(pinIn), .pinOut_q(pinOut_q),
    .pinOeN_q(pinOeN_q), .pullOn_q(pullOn_q), .halted(halted), .wakeReq_q(wakeReq_q));
  pin_env env (.clk(clk), .pinOut(pinOut_q), .oeN(pinOeN_q), .pull(pullOn_q),
    .extOn(extOn), .extVal(extVal), .pinIn(pinIn));
  function automatic logic [7:0] msk(int p);
    return p == 0 ? 8'h1F : p == 5 ? 8'h0F : 8'hFF;
  endfunction : msk
  task chk(string nm, logic [47:0] e, logic [47:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk); addr <= a; wrData <= d; wrEn <= 1;
    @(posedge clk); wrEn <= 0;
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] e, string nm);
    @(posedge clk); addr <= a; rdEn <= 1; expQ.push_back(e); nameQ.push_back(nm);
    @(posedge clk); rdEn <= 0;
  endtask : rd
  task summarize;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  always @(posedge clk) rdSeen <= rdEn;
  always @(negedge clk) if (rdSeen) chk(nameQ.pop_front(), expQ.pop_front(), rdData_q);
  initial begin
    repeat (9) @(posedge clk);
    extVal <= 48'({$random(seed), $random(seed)});
    @(posedge clk); rst <= 0;
    // Pin synchroniser holds reset values for two more edges
    repeat (2) @(posedge clk);
    for (int p = 0; p < 6; p++) begin
      rd(PORT_BASE[p], extVal[p*8+:8] & msk(p), "data");
      rd(PORT_BASE[p] + 8'h1, msk(p), "dir");
      rd(PORT_BASE[p] + 8'h2, 8'h00, "pull");
    end
    rd(8'h13, 8'h00, "wake");
    rd(8'h17, 8'h00, "unmapped");
    for (int p = 0; p < 6; p++) begin
      {pv[p], dv[p], dd[p]} = 24'($random(seed));
      wr(PORT_BASE[p] + 8'h2, pv[p]);
      wr(PORT_BASE[p] + 8'h1, dv[p]);
      wr(PORT_BASE[p], dd[p]);
      rd(PORT_BASE[p] + 8'h2, pv[p] & msk(p), "pull");
    end
    extVal <= ~extVal;
    repeat (3) @(negedge clk);
    for (int p = 0; p < 6; p++) begin
      @(negedge clk);
      chk("oeN", 8'(dv[p] | ~msk(p)), pinOeN_q[p*8+:8]);
      chk("drive", dd[p] & msk(p), pinOut_q[p*8+:8]);
      chk("pullOn", pv[p] & dv[p] & msk(p), pullOn_q[p*8+:8]);
      rd(PORT_BASE[p], (dd[p] & ~dv[p] | extVal[p*8+:8] & dv[p]) & msk(p), "data");
    end
    wr(PORT_BASE[1] + 8'h2, 8'hFF);
    wr(PORT_BASE[1] + 8'h1, 8'hFF);
    extOn[15:8] <= 8'h00;
    repeat (3) @(posedge clk);
    rd(PORT_BASE[1], 8'hFF, "pullPin");
    extOn[15:8] <= 8'hFF;
    // Port A high before its outputs turn to inputs, so no stray fall
    extVal[4:0] <= 5'h1F;
    wr(8'h11, 8'h1F);
    wr(8'h13, 8'hFC);
    halted <= 1;
    rd(8'h13, 8'h1C, "wake");
    repeat (3) @(posedge clk);
    extVal[1] <= 0;
    repeat (6) @(negedge clk);
    chk("wakeOff", 0, wakeReq_q);
    @(posedge clk); extVal[2] <= 0;
    for (i = 0; i < 8 && wakeReq_q !== 1'b1; i++) @(negedge clk);
    chk("wake", 1, wakeReq_q);
    @(posedge clk); halted <= 0;
    repeat (2) @(negedge clk);
    chk("wakeClr", 0, wakeReq_q);
    summarize();
  end
endmodule : gpio_ports_tb
`default_nettype wire
